// >>> hw/sws_datapath.sv
// Operation
// [RULE_01] host enables search mode only after bus reset and search command byte
// [RULE_02] host sequence: reset command, search byte, then search mode command
// [RULE_03] one search pass is sixteen bytes; each byte yields one response byte
// [RULE_04] search byte carries four positions; odd bits are route choices
// [RULE_05] each position runs read slot, complement read slot, then write slot
// [RULE_06] write value: route on conflict, first read otherwise, one if silent
// [RULE_07] both reads zero is conflict; both reads one is no response
// [RULE_08] response byte: odd bit chosen path, even bit discrepancy per position
// [RULE_09] discrepancy is one on conflict or no response, else zero
// [RULE_10] chosen path bit equals the value driven in the write slot
// [RULE_11] after an error all later path bits are one until mode exits
// [RULE_12] host treats path and discrepancy of position 63 both one as failure
// [RULE_13] host route update: flip highest discrepancy, clear above, stop on repeat
// [RULE_14] host clears search mode when searching ends
// [RULE_15] data offset writes transmit buffer, reads separate receive buffer
// [RULE_16] transmit byte moves to shifter and goes out LSB first
// [RULE_17] waiting buffer byte loads as soon as the shifter empties; here it also waits until the last response byte is queued
// [RULE_18] host write clears buffer-empty; transfer clears shifter-empty, sets buffer-empty
// [RULE_19] receive captures wired-AND of sent and slave bits; send ff to read
// [RULE_20] full receive shifter copies to receive buffer; host read clears flag
// [RULE_21] host avoids new transfers while receive buffer is full
// [RULE_22] host writes zero to command register before ordinary traffic
// [RULE_23] command bit 1 selects search mode; cleared by reset
// [RULE_24] bus reset command clears search mode; reset bit self-clears when done
`timescale 1ns/100ps
`default_nettype none
module sws_datapath
	import sws_pkg::*;
#(
	parameter int RX_FIFO_DEPTH = SWS_RX_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic reg_en_b,
	input wire logic reg_rd_b,
	input wire logic reg_wr_b,
	input wire logic [7:0] reg_din,
	output logic [7:0] reg_dout,
	output logic reg_dout_oe,
	input wire logic dq_i,
	output logic dq_o,
	output logic dq_oe
);
	if (RX_FIFO_DEPTH < 2 || (RX_FIFO_DEPTH & (RX_FIFO_DEPTH - 1)) != 0) begin : g_bad_param
		$error("sws_datapath: RX_FIFO_DEPTH must be a power of two >= 2");
	end

	// the prescaler counter is seven bits wide
	if (SWS_CLKS_PER_TICK < 2 || SWS_CLKS_PER_TICK > 128) begin : g_bad_tick
		$error("sws_datapath: tick divider does not fit the prescaler");
	end

	// sample and low times must end inside the slot, or a slot would overrun
	if (SWS_SAMPLE_CNT >= SWS_SLOT_CNT || SWS_LOW0_CNT >= SWS_SLOT_CNT) begin : g_bad_slot
		$error("sws_datapath: slot timing does not fit the slot length");
	end

	// presence sample and reset end must follow the reset low time
	if (SWS_RST_SAMPLE_CNT <= SWS_RST_LOW_CNT ||
		SWS_RST_END_CNT <= SWS_RST_SAMPLE_CNT) begin : g_bad_rst
		$error("sws_datapath: reset timing out of order");
	end

	typedef struct packed {
		sws_state_t st;
		logic bus_reset_cmd;
		logic search_accel_mode;
		logic byte_search;
		logic [7:0] tx_buf;
		logic tx_buffer_empty;
		logic [7:0] tx_sh;
		logic tx_shifter_empty;
		logic [7:0] rx_sh;
		logic rx_pend;
		logic [7:0] rx_buf;
		logic rx_buffer_full;
		logic pres_done;
		logic pres_none;
		logic err;
		logic [2:0] bit_idx;
		logic [1:0] slot;
		logic first_read_slot;
		logic complement_read_slot;
		logic route_write_slot;
		logic [9:0] us_cnt;
		logic [6:0] pre_cnt;
		logic rd_prev;
		logic wr_prev;
		logic [2:0] rd_addr;
		logic [7:0] dout;
	} sws_core_regs_t;

	sws_core_regs_t q;
	sws_core_regs_t n;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;

	// finished receive bytes queue here; a full queue holds the transmit side
	sws_fifo #(
		.WIDTH(8),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(q.rx_pend),
		.in_ready(fifo_in_ready),
		.in_data(q.rx_sh),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	logic tick;
	logic wr_act;
	logic rd_act;
	logic cur_val;
	logic drive;
	logic b0;
	logic b1;
	logic conflict;
	logic no_resp;
	logic route;
	logic wval;
	logic [7:0] rd_mux;
	logic [2:0] pos_even;
	logic [2:0] pos_odd;

	assign fifo_out_ready = !q.rx_buffer_full;
	assign dq_o = 1'b0;
	assign dq_oe = drive;
	assign reg_dout = q.dout;
	assign reg_dout_oe = rd_act;

	always_comb begin
		n = q;
		tick = (q.pre_cnt == SWS_TICK_LAST);
		n.pre_cnt = tick ? 7'h00 : q.pre_cnt + 7'h01;
		wr_act = !reg_en_b && !reg_wr_b;
		// write takes precedence over read
		rd_act = !reg_en_b && !reg_rd_b && reg_wr_b;
		n.wr_prev = wr_act;
		n.rd_prev = rd_act;
		pos_even = {q.bit_idx[1:0], 1'b0};
		pos_odd = {q.bit_idx[1:0], 1'b1};
		b0 = q.first_read_slot;
		b1 = dq_i;
		conflict = !b0 && !b1; // RULE_07
		no_resp = b0 && b1; // RULE_07
		route = q.tx_sh[pos_odd]; // RULE_04
		drive = 1'b0;
		cur_val = 1'b1;
		// write slot value; only meaningful at the complement sample
		wval = 1'b1;

		// register read mux
		rd_mux = 8'h00;
		case (reg_addr)
			SWS_ADDR_CMD: begin
				rd_mux[SWS_CMD_RESET_BIT] = q.bus_reset_cmd;
				rd_mux[SWS_CMD_SRA_BIT] = q.search_accel_mode;
				rd_mux[SWS_CMD_LINE_BIT] = dq_i;
			end
			SWS_ADDR_DATA: rd_mux = q.rx_buf; // RULE_15
			SWS_ADDR_STAT: begin
				rd_mux[SWS_STAT_PD_BIT] = q.pres_done;
				rd_mux[SWS_STAT_PDR_BIT] = q.pres_none;
				rd_mux[SWS_STAT_TBE_BIT] = q.tx_buffer_empty;
				rd_mux[SWS_STAT_TX_SHIFTER_EMPTY_BIT] = q.tx_shifter_empty;
				rd_mux[SWS_STAT_RBF_BIT] = q.rx_buffer_full;
				rd_mux[SWS_STAT_RSRF_BIT] = q.rx_pend;
			end
			default: rd_mux = 8'h00;
		endcase
		if (rd_act) begin
			n.rd_addr = reg_addr;
			n.dout = rd_mux;
		end

		// read side effects at the end of the read strobe
		if (q.rd_prev && !rd_act) begin
			if (q.rd_addr == SWS_ADDR_DATA) begin
				n.rx_buffer_full = 1'b0; // RULE_20
			end
			if (q.rd_addr == SWS_ADDR_STAT) begin
				n.pres_done = 1'b0;
			end
		end

		// queue to receive buffer
		if (q.rx_pend && fifo_in_ready) begin
			n.rx_pend = 1'b0;
		end
		if (fifo_out_valid && !q.rx_buffer_full) begin
			n.rx_buf = fifo_out_data; // RULE_20
			n.rx_buffer_full = 1'b1; // RULE_20
		end

		// bus engine
		case (q.st)
			SWS_ST_IDLE: begin
				n.us_cnt = 10'h000;
				if (q.bus_reset_cmd) begin
					n.st = SWS_ST_RESET;
					n.pre_cnt = 7'h00;
				end else if (!q.tx_buffer_empty && !q.rx_pend) begin
					n.tx_sh = q.tx_buf; // RULE_16
					n.tx_buffer_empty = 1'b1; // RULE_18
					n.tx_shifter_empty = 1'b0; // RULE_18
					n.byte_search = q.search_accel_mode;
					n.bit_idx = 3'h0; // RULE_04
					n.slot = SWS_SLOT_B0;
					n.pre_cnt = 7'h00;
					n.st = SWS_ST_SLOT; // RULE_17
				end
			end
			SWS_ST_RESET: begin
				drive = (q.us_cnt < SWS_RST_LOW_CNT);
				if (tick) begin
					n.us_cnt = q.us_cnt + 10'h001;
					if (q.us_cnt == SWS_RST_SAMPLE_CNT) begin
						n.pres_none = dq_i;
					end
					if (q.us_cnt == SWS_RST_END_CNT) begin
						n.bus_reset_cmd = 1'b0; // RULE_24
						n.pres_done = 1'b1;
						n.st = SWS_ST_IDLE;
					end
				end
			end
			SWS_ST_SLOT: begin
				// normal byte: one slot per bit; search byte: three slots per position
				if (!q.byte_search) begin
					cur_val = q.tx_sh[q.bit_idx]; // RULE_16
				end else if (q.slot == SWS_LAST_SLOT) begin
					cur_val = q.route_write_slot; // RULE_10
				end else begin
					cur_val = 1'b1; // RULE_05
				end
				drive = (q.us_cnt < (cur_val ? SWS_LOW1_CNT : SWS_LOW0_CNT));
				if (tick) begin
					n.us_cnt = q.us_cnt + 10'h001;
					if (q.us_cnt == SWS_SAMPLE_CNT) begin
						if (!q.byte_search) begin
							n.rx_sh = {dq_i, q.rx_sh[7:1]}; // RULE_19
						end else if (q.slot == SWS_SLOT_B0) begin
							n.first_read_slot = dq_i; // RULE_05
						end else if (q.slot == SWS_SLOT_B1) begin
							// decision is made here so the write slot can start at once
							n.complement_read_slot = dq_i; // RULE_05
							if (conflict) begin
								wval = route; // RULE_06
							end else if (no_resp) begin
								wval = 1'b1; // RULE_06
							end else begin
								wval = b0; // RULE_06
							end
							if (no_resp) begin
								n.err = 1'b1;
							end
							if (q.err || no_resp) begin
								wval = 1'b1; // RULE_11
							end
							n.route_write_slot = wval;
							n.rx_sh[pos_odd] = wval; // RULE_08 RULE_10
							n.rx_sh[pos_even] = conflict || no_resp; // RULE_08 RULE_09
						end
					end
					// slot end: advance slot, position or bit
					if (q.us_cnt == SWS_SLOT_CNT) begin
						n.us_cnt = 10'h000;
						if (!q.byte_search) begin
							n.bit_idx = q.bit_idx + 3'h1;
							if (q.bit_idx == SWS_LAST_BIT) begin
								n.st = SWS_ST_IDLE;
							end
						end else if (q.slot != SWS_LAST_SLOT) begin
							n.slot = q.slot + 2'h1; // RULE_05
						end else begin
							n.slot = SWS_SLOT_B0;
							n.bit_idx = q.bit_idx + 3'h1;
							if (q.bit_idx == SWS_LAST_POS) begin
								n.st = SWS_ST_IDLE;
							end
						end
						if (n.st == SWS_ST_IDLE) begin
							// one response byte per transmit byte
							n.rx_pend = 1'b1; // RULE_03 RULE_20
							n.tx_shifter_empty = 1'b1; // RULE_17
						end
					end
				end
			end
			default: begin
				n.st = SWS_ST_IDLE;
			end
		endcase

		// host writes last so a write never loses to a transfer
		if (wr_act && !q.wr_prev) begin
			case (reg_addr)
				SWS_ADDR_CMD: begin
					n.search_accel_mode = reg_din[SWS_CMD_SRA_BIT]; // RULE_23
					if (reg_din[SWS_CMD_RESET_BIT]) begin
						n.bus_reset_cmd = 1'b1;
						n.search_accel_mode = 1'b0; // RULE_24
					end
				end
				SWS_ADDR_DATA: begin
					n.tx_buf = reg_din; // RULE_15
					n.tx_buffer_empty = 1'b0; // RULE_18
				end
				default: begin
					n.tx_buf = n.tx_buf;
				end
			endcase
		end

		// error sticks only while search mode stays on
		if (!n.search_accel_mode) begin
			n.err = 1'b0; // RULE_11
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
			q.tx_buf <= SWS_DATA_RESET;
			q.rx_buf <= SWS_DATA_RESET;
			q.tx_buffer_empty <= SWS_TBE_RESET;
			q.tx_shifter_empty <= SWS_TX_SHIFTER_EMPTY_RESET;
			q.pres_none <= SWS_PDR_RESET;
			q.search_accel_mode <= SWS_SRA_RESET; // RULE_23
			q.st <= SWS_ST_IDLE;
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// >>> hw/sws_pkg.sv
package sws_pkg;

	// register port offsets
	localparam logic [2:0] SWS_ADDR_CMD = 3'h0;
	localparam logic [2:0] SWS_ADDR_DATA = 3'h1;
	localparam logic [2:0] SWS_ADDR_STAT = 3'h2;

	// command register fields
	localparam int SWS_CMD_RESET_BIT = 0;
	localparam int SWS_CMD_SRA_BIT = 1;
	localparam int SWS_CMD_LINE_BIT = 3;

	// status register fields
	localparam int SWS_STAT_PD_BIT = 0;
	localparam int SWS_STAT_PDR_BIT = 1;
	localparam int SWS_STAT_TBE_BIT = 2;
	localparam int SWS_STAT_TX_SHIFTER_EMPTY_BIT = 3;
	localparam int SWS_STAT_RBF_BIT = 4;
	localparam int SWS_STAT_RSRF_BIT = 5;

	// values after reset
	localparam logic [7:0] SWS_DATA_RESET = 8'h00;
	localparam logic SWS_TBE_RESET = 1'b1;
	localparam logic SWS_TX_SHIFTER_EMPTY_RESET = 1'b1;
	localparam logic SWS_PDR_RESET = 1'b1;
	localparam logic SWS_SRA_RESET = 1'b0;

	// clock and microsecond tick
	localparam int SWS_CLK_MHZ = 100;
	localparam int SWS_TICK_US = 1;
	localparam int SWS_CLKS_PER_TICK = SWS_CLK_MHZ * SWS_TICK_US;
	localparam logic [6:0] SWS_TICK_LAST = 7'(SWS_CLKS_PER_TICK - 1);

	// bus timing in microseconds
	localparam int SWS_T_RST_LOW_US = 480;
	localparam int SWS_T_RST_SAMPLE_US = 550;
	localparam int SWS_T_RST_END_US = 960;
	localparam int SWS_T_LOW1_US = 6;
	localparam int SWS_T_LOW0_US = 60;
	localparam int SWS_T_SAMPLE_US = 15;
	localparam int SWS_T_SLOT_US = 70;

	// same timing as tick counts
	localparam logic [9:0] SWS_RST_LOW_CNT = 10'(SWS_T_RST_LOW_US / SWS_TICK_US);
	localparam logic [9:0] SWS_RST_SAMPLE_CNT = 10'(SWS_T_RST_SAMPLE_US / SWS_TICK_US);
	localparam logic [9:0] SWS_RST_END_CNT = 10'(SWS_T_RST_END_US / SWS_TICK_US);
	localparam logic [9:0] SWS_LOW1_CNT = 10'(SWS_T_LOW1_US / SWS_TICK_US);
	localparam logic [9:0] SWS_LOW0_CNT = 10'(SWS_T_LOW0_US / SWS_TICK_US);
	localparam logic [9:0] SWS_SAMPLE_CNT = 10'(SWS_T_SAMPLE_US / SWS_TICK_US);
	localparam logic [9:0] SWS_SLOT_CNT = 10'(SWS_T_SLOT_US / SWS_TICK_US);

	// byte framing
	localparam logic [2:0] SWS_LAST_BIT = 3'h7;
	localparam logic [2:0] SWS_LAST_POS = 3'h3;
	localparam logic [1:0] SWS_LAST_SLOT = 2'h2;
	localparam logic [1:0] SWS_SLOT_B0 = 2'h0;
	localparam logic [1:0] SWS_SLOT_B1 = 2'h1;
	localparam int SWS_SEARCH_BYTES = 16;
	localparam int SWS_RX_FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		SWS_ST_IDLE = 2'b00,
		SWS_ST_RESET = 2'b01,
		SWS_ST_SLOT = 2'b10
	} sws_state_t;

endpackage

// >>> hw/sws_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sws_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
		$error("sws_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} sws_fifo_regs_t;

	sws_fifo_regs_t q;
	sws_fifo_regs_t n;

	always_comb begin
		n = q;
		out_valid = (q.wp != q.rp);
		in_ready = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
		out_data = q.mem[q.rp[AW-1:0]];
		if (in_valid && in_ready) begin
			n.mem[q.wp[AW-1:0]] = in_data;
			n.wp = q.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			n.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// >>> sim/sws_datapath_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sws_datapath_checker
	import sws_pkg::*;
#(
	parameter int RX_FIFO_DEPTH = SWS_RX_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic reg_en_b,
	input wire logic reg_rd_b,
	input wire logic reg_wr_b,
	input wire logic [7:0] reg_din,
	input wire logic [7:0] reg_dout,
	input wire logic reg_dout_oe,
	input wire logic dq_i,
	input wire logic dq_o,
	input wire logic dq_oe
);
	logic [16:0] lo_r;
	logic [16:0] rise_r;
	logic [16:0] fall_r;
	logic wr_go;
	logic rd_go;
	assign wr_go = !reg_en_b && !reg_wr_b;
	assign rd_go = !reg_en_b && !reg_rd_b && reg_wr_b;
	// low length, spacing of slot starts, idle time
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lo_r <= '0;
			rise_r <= '1;
			fall_r <= '1;
		end else begin
			lo_r <= dq_oe ? lo_r + 17'h1 : '0;
			rise_r <= (dq_oe && lo_r == '0) ? 17'h1 : rise_r + {16'h0, rise_r != '1};
			fall_r <= dq_oe ? '0 : fall_r + {16'h0, fall_r != '1};
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_oe_decode: assert property (reg_dout_oe == rd_go)
		else $error("read enable mismatch");
	a_unmapped_zero: assert property (rd_go && reg_addr > SWS_ADDR_STAT |=> reg_dout == 8'h00)
		else $error("unmapped read not zero");
	a_dout_hold: assert property (!rd_go |=> $stable(reg_dout))
		else $error("read data moved without read");
	a_open_drain: assert property (dq_o == 1'b0)
		else $error("line driven high");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !dq_oe)
		else $error("line pulled in reset");
	a_pulse_len: assert property ($fell(dq_oe) |->
		lo_r inside {[500:700], [5900:6100], [47900:48100]})
		else $error("bad low time");
	a_slot_gap: assert property ($rose(dq_oe) |-> rise_r >= 17'd7000)
		else $error("slots too close");
	a_tx_start: assert property (wr_go && $past(reg_wr_b) && reg_addr == SWS_ADDR_DATA &&
		fall_r > 17'd60000 |-> ##[1:4] dq_oe)
		else $error("idle byte not started");
	a_reset_start: assert property (wr_go && $past(reg_wr_b) && reg_addr == SWS_ADDR_CMD &&
		reg_din[0] && fall_r > 17'd60000 |-> ##[1:4] dq_oe ##1 dq_oe[*8])
		else $error("bus reset not started");
	c_long_low: cover property ($fell(dq_oe) && lo_r > 17'd5000);
	c_data_read: cover property (rd_go && reg_addr == SWS_ADDR_DATA);
	c_mode_write: cover property (wr_go && reg_addr == SWS_ADDR_CMD && reg_din[1]);
endmodule
bind sws_datapath sws_datapath_checker #(.RX_FIFO_DEPTH(RX_FIFO_DEPTH)) u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_en_b(reg_en_b),
	.reg_rd_b(reg_rd_b), .reg_wr_b(reg_wr_b), .reg_din(reg_din), .reg_dout(reg_dout),
	.reg_dout_oe(reg_dout_oe), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe)
);
`default_nettype wire

// >>> sim/sws_slaves.sv
`timescale 1ns/100ps
`default_nettype none
// two search responders; both fall silent from position quit_pos on
module sws_slaves (
	input wire logic dq_oe,
	input wire logic dq_line,
	input wire logic [3:0] rom_a,
	input wire logic [3:0] rom_b,
	input wire logic [2:0] quit_pos,
	output logic pull_low
);
	int slot = 0;
	logic live_a = 1'b1;
	logic live_b = 1'b1;
	initial pull_low = 1'b0;
	always @(posedge dq_oe) begin : slot_proc
		int p;
		int k;
		p = slot / 3;
		k = slot % 3;
		slot = slot + 1;
		if (p < quit_pos) begin
			if (k == 2) begin
				#30000;
				// drop out when the written path differs
				live_a = live_a && (dq_line === rom_a[p]);
				live_b = live_b && (dq_line === rom_b[p]);
			end else begin
				pull_low = (live_a && rom_a[p] == k[0]) || (live_b && rom_b[p] == k[0]);
				#40000;
				pull_low = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/single_wire_search_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
module single_wire_search_datapath_bench
	import sws_pkg::*;
;
	typedef struct {
		logic [2:0] addr;
		logic [7:0] exp;
	} sws_row_t;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic reg_en_b = 1'b1;
	logic reg_rd_b = 1'b1;
	logic reg_wr_b = 1'b1;
	logic [7:0] reg_din = 8'h00;
	logic [7:0] reg_dout;
	logic reg_dout_oe;
	logic dq_o;
	logic dq_oe;
	logic slv_low;
	wire dq_i;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] rd;
	sws_row_t rows [5] = '{'{3'h0, 8'h08}, '{3'h1, 8'h00}, '{3'h2, 8'h0e},
		'{3'h3, 8'h00}, '{3'h7, 8'h00}};
	always #5 core_clk = ~core_clk;
	// pull-up: line high unless someone pulls it
	assign dq_i = !(dq_oe || slv_low);
	sws_datapath u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_en_b(reg_en_b),
		.reg_rd_b(reg_rd_b), .reg_wr_b(reg_wr_b), .reg_din(reg_din), .reg_dout(reg_dout),
		.reg_dout_oe(reg_dout_oe), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe)
	);
	sws_slaves u_slv (
		.dq_oe(dq_oe), .dq_line(dq_i), .rom_a(4'ha), .rom_b(4'h5), .quit_pos(3'h3),
		.pull_low(slv_low)
	);
	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_din = d;
		reg_en_b = 1'b0;
		reg_wr_b = 1'b0;
		@(negedge core_clk);
		reg_en_b = 1'b1;
		reg_wr_b = 1'b1;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_en_b = 1'b0;
		reg_rd_b = 1'b0;
		repeat (2) @(negedge core_clk);
		d = reg_dout;
		reg_en_b = 1'b1;
		reg_rd_b = 1'b1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		reg_rd(a, rd);
		chk(rd, exp);
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst_b = 1'b1;
		reg_wr(3'h3, 8'hff);
		foreach (rows[i]) begin
			rd_chk(rows[i].addr, rows[i].exp);
		end
		reg_wr(SWS_ADDR_CMD, 8'h02);
		rd_chk(SWS_ADDR_CMD, 8'h0a);
		// route 1 at position 0, fillers set and unused routes clear to expose misuse
		reg_wr(SWS_ADDR_DATA, 8'h57);
		rd_chk(SWS_ADDR_STAT, 8'h06);
		rd_chk(SWS_ADDR_DATA, 8'h00);
		reg_wr(SWS_ADDR_DATA, 8'h5a);
		rd_chk(SWS_ADDR_STAT, 8'h02);
		rd = 8'h00;
		while (rd[4] !== 1'b1) begin
			repeat (500) @(negedge core_clk);
			reg_rd(SWS_ADDR_STAT, rd);
		end
		// conflict, plain 0, plain 1, silence
		rd_chk(SWS_ADDR_DATA, 8'he3);
		rd_chk(SWS_ADDR_STAT, 8'h06);
		reg_wr(SWS_ADDR_CMD, 8'h00);
		reg_rd(SWS_ADDR_CMD, rd);
		chk(rd & 8'h07, 8'h00);
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		rd_chk(SWS_ADDR_STAT, 8'h0e);
		rd_chk(SWS_ADDR_CMD, 8'h08);
		reg_wr(SWS_ADDR_CMD, 8'h03);
		rd_chk(SWS_ADDR_CMD, 8'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
